/* hdl/sirq_cfg.sv */
// serial irq mode, trigger type and level status registers with the frame engine
// assumes memory window and config space ports are synchronous to sys_clk
// and that each port raises rd or wr for one cycle per access
`timescale 1ns/10ps
module sirq_cfg import sirq_pkg::*; (
	input wire logic sys_clk, // bridge clock, 20 MHz
	input wire logic rst_b, // power-on reset, async, active low
	input wire logic fundamental_reset_n, // fundamental reset, sync, active low
	input wire logic global_reset_n, // global reset, sync, active low
	input sirq_req_type mem_req, // device control memory window access
	output sirq_rsp_type mem_rsp, // memory window answer
	input sirq_req_type cfg_req, // config space access
	output sirq_rsp_type cfg_rsp, // config space answer
	input wire logic serirq_in, // serial irq line level
	output logic serirq_out, // serial irq line drive level
	output logic serirq_oe // high while driving the line
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [1:0] width; // start width code
		logic quiet; // quiet select
		logic tristate; // recovery tristate select
		logic [15:0] level_sel; // line level selects, bit n = line n
		logic [15:0] pending; // level status, bit n = line n
		sirq_rsp_type mem_rsp; // registered memory window answer
		sirq_rsp_type cfg_rsp; // registered config space answer
	} sirq_cfg_state_type;

	localparam sirq_cfg_state_type SIRQ_CFG_RST = '{
		width: SIRQ_WIDTH_RST, quiet: 1'b0, tristate: 1'b0,
		level_sel: SIRQ_TRIG_RST, pending: SIRQ_STAT_RST,
		mem_rsp: '{ack: 1'b0, rdata: SIRQ_RDATA_NONE},
		cfg_rsp: '{ack: 1'b0, rdata: SIRQ_RDATA_NONE}};

	sirq_cfg_state_type s_r; // registered state
	sirq_cfg_state_type s_nxt; // next state

	logic bridge_clr; // any synchronous bridge reset
	sirq_mode_type mode; // configuration seen by the engine
	logic [15:0] seen; // lines asserted in the last frame
	logic seen_vld; // frame result strobe

	// ****************************************************************
	// address decode
	// ****************************************************************
	// both access paths share one decode; only the bases differ
	function automatic sirq_sel_type sirq_decode(
		input logic [7:0] addr,
		input logic [7:0] mode_ofs,
		input logic [7:0] trig_ofs,
		input logic [7:0] stat_ofs
	);
		sirq_sel_type sel;
		sel = SIRQ_SEL_NONE;
		if (addr == mode_ofs) begin
			sel = SIRQ_SEL_MODE;
		end else if (addr == trig_ofs) begin
			sel = SIRQ_SEL_TRIG;
		end else if (addr == stat_ofs) begin
			sel = SIRQ_SEL_STAT;
		end else begin
			sel = SIRQ_SEL_NONE;
		end
		return sel;
	endfunction : sirq_decode

	// read view of a register; unmapped reads return zero
	function automatic logic [15:0] sirq_read(
		input sirq_sel_type sel,
		input sirq_cfg_state_type s
	);
		logic [15:0] d;
		d = SIRQ_RDATA_NONE;
		case (sel)
			SIRQ_SEL_MODE: d = {8'h00, SIRQ_MODE_RSVD_VAL, s.width, s.quiet, s.tristate};
			SIRQ_SEL_TRIG: d = s.level_sel;
			SIRQ_SEL_STAT: d = s.pending;
			default: d = SIRQ_RDATA_NONE;
		endcase
		return d;
	endfunction : sirq_read

	// expand byte enables to a bit mask
	function automatic logic [15:0] sirq_mask(input logic [1:0] be);
		return {{8{be[1]}}, {8{be[0]}}};
	endfunction : sirq_mask

	// ****************************************************************
	// decoded selects for both paths
	// ****************************************************************
	sirq_sel_type mem_sel; // memory window target
	sirq_sel_type cfg_sel; // config space target

	assign mem_sel = sirq_decode(mem_req.addr, SIRQ_MEM_MODE_OFS, SIRQ_MEM_TRIG_OFS,
		SIRQ_MEM_STAT_OFS);
	assign cfg_sel = sirq_decode(cfg_req.addr, SIRQ_CFG_MODE_OFS, SIRQ_CFG_TRIG_OFS,
		SIRQ_CFG_STAT_OFS);

	assign bridge_clr = !fundamental_reset_n || !global_reset_n;

	// ****************************************************************
	// register update
	// ****************************************************************
	// one set of storage serves both paths, so an alias write is seen at once
	// through the other path; on a same-cycle collision config space wins for mode and trigger, while status clears from both paths apply
	always_comb begin
		logic [15:0] clr_mask; // write-one-to-clear bits from both paths
		logic [15:0] set_mask; // level lines reported this frame
		logic [15:0] m; // byte mask of the current write
		clr_mask = 16'h0000;
		set_mask = 16'h0000;
		m = 16'h0000;
		s_nxt = s_r;

		// memory window write
		if (mem_req.wr) begin
			m = sirq_mask(mem_req.be);
			if (mem_sel == SIRQ_SEL_MODE && mem_req.be[0]) begin
				s_nxt.width = mem_req.wdata[SIRQ_WIDTH_MSB:SIRQ_WIDTH_LSB];
				s_nxt.quiet = mem_req.wdata[SIRQ_QUIET_BIT];
				s_nxt.tristate = mem_req.wdata[SIRQ_TRI_BIT];
			end else if (mem_sel == SIRQ_SEL_TRIG) begin
				s_nxt.level_sel = (s_nxt.level_sel & ~m) | (mem_req.wdata & m);
			end else if (mem_sel == SIRQ_SEL_STAT) begin
				clr_mask = clr_mask | (mem_req.wdata & m);
			end
		end

		// config space write, same storage
		if (cfg_req.wr) begin
			m = sirq_mask(cfg_req.be);
			if (cfg_sel == SIRQ_SEL_MODE && cfg_req.be[0]) begin
				s_nxt.width = cfg_req.wdata[SIRQ_WIDTH_MSB:SIRQ_WIDTH_LSB];
				s_nxt.quiet = cfg_req.wdata[SIRQ_QUIET_BIT];
				s_nxt.tristate = cfg_req.wdata[SIRQ_TRI_BIT];
			end else if (cfg_sel == SIRQ_SEL_TRIG) begin
				s_nxt.level_sel = (s_nxt.level_sel & ~m) | (cfg_req.wdata & m);
			end else if (cfg_sel == SIRQ_SEL_STAT) begin
				clr_mask = clr_mask | (cfg_req.wdata & m);
			end
		end

		// only lines in level mode report; edge lines are dropped here
		if (seen_vld) begin
			set_mask = seen & s_r.level_sel;
		end

		// a set in the same cycle as a clear survives the clear
		s_nxt.pending = (s_r.pending & ~clr_mask) | set_mask;

		// answers are registered and show the value before this cycle's write
		s_nxt.mem_rsp.ack = mem_req.rd || mem_req.wr;
		s_nxt.mem_rsp.rdata = mem_req.rd ? sirq_read(mem_sel, s_r) : SIRQ_RDATA_NONE;
		s_nxt.cfg_rsp.ack = cfg_req.rd || cfg_req.wr;
		s_nxt.cfg_rsp.rdata = cfg_req.rd ? sirq_read(cfg_sel, s_r) : SIRQ_RDATA_NONE;

		// fundamental or global reset returns every field to its default
		if (bridge_clr) begin
			s_nxt = SIRQ_CFG_RST;
		end
	end

	// state register; power-on reset acts asynchronously
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= SIRQ_CFG_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************************************
	// frame engine
	// ****************************************************************
	assign mode = '{width: s_r.width, quiet: s_r.quiet, tristate: s_r.tristate};

	// the engine is restarted by the same resets so no half frame survives them
	sirq_frame u_frame (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.clr(bridge_clr),
		.mode(mode),
		.line_in(serirq_in),
		.line_out(serirq_out),
		.line_oe(serirq_oe),
		.seen(seen),
		.seen_vld(seen_vld)
	);

	assign mem_rsp = s_r.mem_rsp;
	assign cfg_rsp = s_r.cfg_rsp;

endmodule : sirq_cfg

/* include/sirq_pkg.sv */
// constants, field layouts and carrier types for the serial irq configuration and status block
// assumes a single 20 MHz bridge clock and register ports driven synchronously to it
// Function
// - width field sets start pulse 4/6/8
// - polling bit selects continuous or quiet
// - drive bit: recovery high or tristate
// - mode bits 7:4 read zero
// - one level/edge bit per line 0..15
// - trigger bits cleared by three resets
// - asserted level line sets its status bit
// - write one clears status, zero keeps
// - edge lines never set status bits
// - config space aliases E0h E2h E4h
// - memory window offsets 48h 4Ah 4Ch
package sirq_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0] SIRQ_MEM_MODE_OFS = 8'h48; // mode control, memory window
	localparam logic [7:0] SIRQ_MEM_TRIG_OFS = 8'h4a; // trigger type, memory window
	localparam logic [7:0] SIRQ_MEM_STAT_OFS = 8'h4c; // level status, memory window
	localparam logic [7:0] SIRQ_CFG_MODE_OFS = 8'he0; // mode control, config space
	localparam logic [7:0] SIRQ_CFG_TRIG_OFS = 8'he2; // trigger type, config space
	localparam logic [7:0] SIRQ_CFG_STAT_OFS = 8'he4; // level status, config space

	// ****************************************************************
	// field layout and reset values
	// ****************************************************************
	localparam int SIRQ_LINES = 16; // serial interrupt lines handled
	localparam int SIRQ_TRI_BIT = 0; // recovery tristate select
	localparam int SIRQ_QUIET_BIT = 1; // quiet select
	localparam int SIRQ_WIDTH_LSB = 2; // start width field low bit
	localparam int SIRQ_WIDTH_MSB = 3; // start width field high bit
	localparam logic [3:0] SIRQ_MODE_RSVD_VAL = 4'h0; // reserved mode bits
	localparam logic [1:0] SIRQ_WIDTH_RST = 2'h0; // start width reset code
	localparam logic [15:0] SIRQ_TRIG_RST = 16'h0000; // all lines edge
	localparam logic [15:0] SIRQ_STAT_RST = 16'h0000; // nothing pending
	localparam logic [15:0] SIRQ_RDATA_NONE = 16'h0000; // unmapped read answer

	// ****************************************************************
	// frame timing in clocks
	// ****************************************************************
	localparam logic [3:0] SIRQ_START_4 = 4'h4; // code 00
	localparam logic [3:0] SIRQ_START_6 = 4'h6; // code 01
	localparam logic [3:0] SIRQ_START_8 = 4'h8; // code 10
	localparam logic [3:0] SIRQ_STOP_QUIET = 4'h2; // stop pulse, quiet next
	localparam logic [3:0] SIRQ_STOP_CONT = 4'h3; // stop pulse, continuous next
	localparam logic [3:0] SIRQ_IDLE_GAP = 4'h4; // idle count that starts the next continuous frame; 5 idle clocks between frames
	localparam logic [1:0] SIRQ_PHASE_LAST = 2'h2; // sample, recovery, turnaround
	localparam logic [3:0] SIRQ_SLOT_LAST = 4'hf; // last irq slot

	// ****************************************************************
	// types
	// ****************************************************************
	// register index after address decode
	typedef enum logic [1:0] {
		SIRQ_SEL_NONE = 2'h0,
		SIRQ_SEL_MODE = 2'h1,
		SIRQ_SEL_TRIG = 2'h2,
		SIRQ_SEL_STAT = 2'h3
	} sirq_sel_type;

	// frame engine states, gray along the frame path
	typedef enum logic [2:0] {
		SIRQ_ST_IDLE = 3'h0,
		SIRQ_ST_START = 3'h1,
		SIRQ_ST_SREC = 3'h3,
		SIRQ_ST_STURN = 3'h2,
		SIRQ_ST_SLOT = 3'h6,
		SIRQ_ST_STOP = 3'h7,
		SIRQ_ST_PREC = 3'h5,
		SIRQ_ST_PTURN = 3'h4
	} sirq_state_type;

	// one register access request
	typedef struct packed {
		logic rd; // read strobe
		logic wr; // write strobe
		logic [7:0] addr; // byte offset
		logic [1:0] be; // byte enables, bit 0 = low byte
		logic [15:0] wdata; // write data
	} sirq_req_type;

	// one register access answer
	typedef struct packed {
		logic ack; // one-cycle answer strobe
		logic [15:0] rdata; // read data
	} sirq_rsp_type;

	// configuration handed to the frame engine
	typedef struct packed {
		logic [1:0] width; // start width code
		logic quiet; // quiet select
		logic tristate; // recovery tristate select
	} sirq_mode_type;

	// start pulse length for a width code
	function automatic logic [3:0] sirq_start_clocks(input logic [1:0] code);
		logic [3:0] n;
		n = SIRQ_START_4;
		case (code)
			2'h1: n = SIRQ_START_6;
			2'h2: n = SIRQ_START_8;
			default: n = SIRQ_START_4;
		endcase
		return n;
	endfunction : sirq_start_clocks

endpackage : sirq_pkg

/* hdl/sirq_frame.sv */
// serial interrupt frame engine: start pulse, slot sampling, stop pulse
// assumes the line input is already synchronous to sys_clk; pad resolves the wire
`timescale 1ns/10ps
module sirq_frame import sirq_pkg::*; (
	input wire logic sys_clk, // bridge clock
	input wire logic rst_b, // async reset, active low
	input wire logic clr, // synchronous clear from the bridge resets
	input sirq_mode_type mode, // live configuration
	input wire logic line_in, // serial irq line level
	output logic line_out, // level driven on the line
	output logic line_oe, // high while driving the line
	output logic [15:0] seen, // lines seen asserted in last frame
	output logic seen_vld // one-cycle pulse at frame end
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		sirq_state_type st; // frame position
		logic [3:0] cnt; // clocks within a pulse or gap
		logic [3:0] slot; // current irq slot
		logic [1:0] phase; // phase inside the slot
		logic [15:0] acc; // slots sampled low so far
		logic [15:0] seen; // frozen result
		logic vld; // result strobe
		logic out; // line level
		logic oe; // line enable
	} sirq_frame_state_type;

	localparam sirq_frame_state_type SIRQ_FRAME_RST = '{
		st: SIRQ_ST_IDLE, cnt: 4'h0, slot: 4'h0, phase: 2'h0,
		acc: SIRQ_STAT_RST, seen: SIRQ_STAT_RST, vld: 1'b0, out: 1'b1, oe: 1'b0};

	sirq_frame_state_type s_r; // registered state
	sirq_frame_state_type s_nxt; // next state

	// ****************************************************************
	// next state
	// ****************************************************************
	// outputs are derived from the next state so the pin moves with the state
	always_comb begin
		s_nxt = s_r;
		s_nxt.vld = 1'b0;
		case (s_r.st)
			SIRQ_ST_IDLE: begin
				if (mode.quiet) begin
					// quiet: a peripheral pulling low starts the frame
					s_nxt.cnt = 4'h0;
					if (!line_in) begin
						s_nxt.st = SIRQ_ST_START;
					end
				end else if (s_r.cnt >= SIRQ_IDLE_GAP) begin
					s_nxt.st = SIRQ_ST_START;
					s_nxt.cnt = 4'h0;
				end else begin
					s_nxt.cnt = s_r.cnt + 4'h1;
				end
			end
			SIRQ_ST_START: begin
				// count the start pulse to the programmed width
				if (s_r.cnt + 4'h1 >= sirq_start_clocks(mode.width)) begin
					s_nxt.st = SIRQ_ST_SREC;
				end
				s_nxt.cnt = s_r.cnt + 4'h1;
			end
			SIRQ_ST_SREC: begin
				s_nxt.st = SIRQ_ST_STURN;
			end
			SIRQ_ST_STURN: begin
				s_nxt.st = SIRQ_ST_SLOT;
				s_nxt.slot = 4'h0;
				s_nxt.phase = 2'h0;
				s_nxt.acc = SIRQ_STAT_RST;
			end
			SIRQ_ST_SLOT: begin
				// a low level in the sample phase means the line is asserted
				if (s_r.phase == 2'h0 && !line_in) begin
					s_nxt.acc[s_r.slot] = 1'b1;
				end
				if (s_r.phase == SIRQ_PHASE_LAST) begin
					s_nxt.phase = 2'h0;
					s_nxt.slot = s_r.slot + 4'h1;
					if (s_r.slot == SIRQ_SLOT_LAST) begin
						s_nxt.st = SIRQ_ST_STOP;
						s_nxt.cnt = 4'h0;
					end
				end else begin
					s_nxt.phase = s_r.phase + 2'h1;
				end
			end
			SIRQ_ST_STOP: begin
				// stop length tells peripherals which mode follows
				if (s_r.cnt + 4'h1 >= (mode.quiet ? SIRQ_STOP_QUIET : SIRQ_STOP_CONT)) begin
					s_nxt.st = SIRQ_ST_PREC;
				end
				s_nxt.cnt = s_r.cnt + 4'h1;
			end
			SIRQ_ST_PREC: begin
				s_nxt.st = SIRQ_ST_PTURN;
			end
			default: begin
				// turnaround done: publish the frame and go idle
				s_nxt.st = SIRQ_ST_IDLE;
				s_nxt.cnt = 4'h0;
				s_nxt.seen = s_r.acc;
				s_nxt.vld = 1'b1;
			end
		endcase
		// pin drive follows the state being entered
		case (s_nxt.st)
			SIRQ_ST_START, SIRQ_ST_STOP: begin
				s_nxt.out = 1'b0;
				s_nxt.oe = 1'b1;
			end
			SIRQ_ST_SREC, SIRQ_ST_PREC: begin
				s_nxt.out = 1'b1;
				s_nxt.oe = !mode.tristate;
			end
			default: begin
				s_nxt.out = 1'b1;
				s_nxt.oe = 1'b0;
			end
		endcase
		if (clr) begin
			s_nxt = SIRQ_FRAME_RST;
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= SIRQ_FRAME_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign line_out = s_r.out;
	assign line_oe = s_r.oe;
	assign seen = s_r.seen;
	assign seen_vld = s_r.vld;

endmodule : sirq_frame

/* verification/sirq_cfg_assertions.sv */
// concurrent checks on the ports of the serial irq configuration block
// assumes it is bound to sirq_cfg; one clock domain, sys_clk
`timescale 1ns/10ps
module sirq_cfg_chk import sirq_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic fundamental_reset_n,
	input wire logic global_reset_n,
	input sirq_req_type mem_req,
	input sirq_rsp_type mem_rsp,
	input sirq_req_type cfg_req,
	input sirq_rsp_type cfg_rsp,
	input wire logic serirq_in,
	input wire logic serirq_out,
	input wire logic serirq_oe
);
	// ****************************************************************
	// helper logic
	// ****************************************************************
	logic low; // block drives the line low
	logic clr; // either synchronous clear
	logic [3:0] low_cnt_r; // clocks in the current low run
	logic [2:0] mode_r; // shadow of width code and quiet bit
	logic [3:0] exp_len; // start length for the shadow width
	assign low = serirq_oe && !serirq_out;
	assign clr = !fundamental_reset_n || !global_reset_n;
	assign exp_len = (mode_r[2:1] == 2'h1) ? 4'h6 : (mode_r[2:1] == 2'h2) ? 4'h8 : 4'h4;
	// run counter cleared by every reset, so a pulse cut short is never judged
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			low_cnt_r <= 4'h0;
			mode_r <= 3'h0;
		end else if (clr) begin
			low_cnt_r <= 4'h0;
			mode_r <= 3'h0;
		end else begin
			low_cnt_r <= low ? low_cnt_r + 4'h1 : 4'h0;
			// config space wins a same-cycle collision
			if (cfg_req.wr && cfg_req.addr == SIRQ_CFG_MODE_OFS && cfg_req.be[0]) begin
				mode_r <= cfg_req.wdata[3:1];
			end else if (mem_req.wr && mem_req.addr == SIRQ_MEM_MODE_OFS && mem_req.be[0]) begin
				mode_r <= mem_req.wdata[3:1];
			end
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b || clr);
	// ****************************************************************
	// assertions
	// ****************************************************************
	a_mem_ack_next: assert property (mem_req.rd || mem_req.wr |=> mem_rsp.ack)
		else $error("memory window access not answered");
	a_cfg_ack_next: assert property (cfg_req.rd || cfg_req.wr |=> cfg_rsp.ack)
		else $error("config space access not answered");
	a_ack_has_cause: assert property (mem_rsp.ack |-> $past(mem_req.rd || mem_req.wr))
		else $error("answer without a request");
	a_mode_rsvd_zero: assert property (mem_req.rd && mem_req.addr == SIRQ_MEM_MODE_OFS
		|=> mem_rsp.rdata[7:4] == 4'h0) else $error("reserved mode bits not zero");
	a_unmapped_zero: assert property (mem_req.rd && !(mem_req.addr inside {8'h48, 8'h4a, 8'h4c})
		|=> mem_rsp.rdata == 16'h0000) else $error("unmapped read not zero");
	a_start_width: assert property (low_cnt_r >= 4'h4 && !low && !mode_r[0]
		|-> low_cnt_r == exp_len) else $error("start pulse length wrong");
	a_start_max: assert property (low_cnt_r <= 4'h8)
		else $error("line held low too long");
	a_turn_release: assert property (low_cnt_r >= 4'h2 && !low |-> serirq_out ##1 !serirq_oe)
		else $error("recovery or turnaround wrong");
	a_sync_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
		clr |=> !serirq_oe && serirq_out) else $error("line not released after clear");
	// main scenarios reached
	c_long_start: cover property (low_cnt_r == 4'h8 && !low);
	c_tristate_rec: cover property (low_cnt_r >= 4'h4 && !low && !serirq_oe);
	c_quiet_frame: cover property (mode_r[0] && low);
endmodule : sirq_cfg_chk

bind sirq_cfg sirq_cfg_chk chk (.sys_clk(sys_clk), .rst_b(rst_b),
	.fundamental_reset_n(fundamental_reset_n), .global_reset_n(global_reset_n),
	.mem_req(mem_req), .mem_rsp(mem_rsp), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
	.serirq_in(serirq_in), .serirq_out(serirq_out), .serirq_oe(serirq_oe));

/* verification/sirq_periph.sv */
// peripheral model on the serial irq line: pulls low in requested slots, asks for frames
// assumes an open-drain wire with pull-up resolved by the bench
`timescale 1ns/10ps
module sirq_periph (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic line,
	input wire logic drv_oe,
	input wire logic [15:0] req,
	input wire logic start_req,
	output logic pull_low,
	output int frames,
	output logic [3:0] start_len,
	output logic rec_oe
);
	// ****************************************************************
	// frame tracking
	// ****************************************************************
	logic [3:0] low_cnt_r; // wire low run length
	logic [5:0] pos_r; // clock index after start recovery, 0 = outside slots
	logic qlow_r; // one low clock asking for a frame
	logic [5:0] d; // clock index from first slot
	assign d = pos_r - 6'd2;
	// one low clock in the sample phase of each requested slot; released wire floats high
	assign pull_low = qlow_r || (pos_r >= 6'd2 && pos_r <= 6'd47 && d % 6'd3 == 6'd0
		&& req[d / 6'd3]);
	// a low run of 4 or more is a start; shorter runs are stop pulses
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			low_cnt_r <= 4'h0;
			pos_r <= 6'd0;
			qlow_r <= 1'b0;
			frames <= 0;
			start_len <= 4'h0;
			rec_oe <= 1'b0;
		end else begin
			low_cnt_r <= line ? 4'h0 : low_cnt_r + 4'h1;
			qlow_r <= start_req && pos_r == 6'd0 && !drv_oe && line;
			if (line && low_cnt_r >= 4'h4) begin
				pos_r <= 6'd1;
				frames <= frames + 1;
				start_len <= low_cnt_r;
				rec_oe <= drv_oe;
			end else if (pos_r != 6'd0 && pos_r < 6'd50) begin
				pos_r <= pos_r + 6'd1;
			end else begin
				pos_r <= 6'd0;
			end
		end
	end
endmodule : sirq_periph

/* verification/testbench.sv */
// self-checking bench for the serial irq configuration block
// assumes sirq_cfg, its checker bind and the peripheral model are compiled first
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin err_total++; \
	$display("ERROR %s expected %h got %h", nm, e, g); end end
module testbench import sirq_pkg::*;;
	logic sys_clk, rst_b, fundamental_reset_n, global_reset_n;
	logic serirq_in, serirq_out, serirq_oe, start_req, pull_low, rec_oe;
	sirq_req_type mem_req, cfg_req; // register requests
	sirq_rsp_type mem_rsp, cfg_rsp; // register answers
	logic [15:0] req_p, rd, trig, rq, d;
	logic [3:0] start_len;
	logic [1:0] be_sel; // byte enables of the next access
	logic [7:0] ofs [6] = '{8'h48, 8'h4a, 8'h4c, 8'he0, 8'he2, 8'he4};
	int frames, err_total, compares, seed, f, i, w;
	// open-drain wire with pull-up
	assign serirq_in = !((serirq_oe && !serirq_out) || pull_low);
	sirq_cfg dut (.sys_clk(sys_clk), .rst_b(rst_b), .fundamental_reset_n(fundamental_reset_n),
		.global_reset_n(global_reset_n), .mem_req(mem_req), .mem_rsp(mem_rsp),
		.cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .serirq_in(serirq_in),
		.serirq_out(serirq_out), .serirq_oe(serirq_oe));
	sirq_periph peer (.sys_clk(sys_clk), .rst_b(rst_b), .line(serirq_in), .drv_oe(serirq_oe),
		.req(req_p), .start_req(start_req), .pull_low(pull_low), .frames(frames),
		.start_len(start_len), .rec_oe(rec_oe));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic finish_test;
		if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	function automatic logic [3:0] exp_len(input logic [1:0] c);
		exp_len = (c == 2'h1) ? 4'h6 : (c == 2'h2) ? 4'h8 : 4'h4;
	endfunction : exp_len
	// one access; the answer is registered on the taking edge and checked at the next falling edge
	task automatic acc(input logic c, input logic wr, input logic [7:0] a,
		input logic [15:0] wd, output logic [15:0] q);
		sirq_req_type r;
		r = {!wr, wr, a, be_sel, wd};
		@(negedge sys_clk);
		if (c) cfg_req = r;
		else mem_req = r;
		@(negedge sys_clk);
		mem_req = '0;
		cfg_req = '0;
		`CHK("ack", 1'b1, c ? cfg_rsp.ack : mem_rsp.ack)
		q = c ? cfg_rsp.rdata : mem_rsp.rdata;
	endtask : acc
	// wait until the peripheral sees the next start pulse, bounded
	task automatic wait_frame;
		int n, k;
		n = frames;
		for (k = 0; k < 300 && frames == n; k++) @(negedge sys_clk);
		if (frames == n) begin
			err_total++;
			$display("ERROR frame start expected within 300 got none");
			finish_test();
		end
	endtask : wait_frame
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		seed = 32'h28be;
		err_total = 0;
		compares = 0;
		rst_b = 1'b0;
		fundamental_reset_n = 1'b1;
		global_reset_n = 1'b1;
		mem_req = '0;
		cfg_req = '0;
		req_p = '0;
		start_req = 1'b0;
		be_sel = 2'h3;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk) rst_b = 1'b1;
		for (i = 0; i < 6; i++) begin
			acc(i > 2, 1'b0, ofs[i], 16'h0, rd);
			`CHK("reset value", 16'h0000, rd)
		end
		acc(1'b0, 1'b1, 8'h50, 16'hffff, rd);
		acc(1'b0, 1'b0, 8'h50, 16'h0, rd);
		`CHK("unmapped", 16'h0000, rd)
		// every width code, random reserved bits, drive mode, trigger and slot pattern
		for (w = 0; w < 4; w++) begin
			d = $random(seed);
			d[3:1] = {w[1:0], 1'b0};
			trig = $random(seed);
			rq = $random(seed);
			req_p = '0;
			wait_frame();
			acc(w[0], 1'b1, w[0] ? 8'he0 : 8'h48, d, rd);
			acc(!w[0], 1'b0, w[0] ? 8'h48 : 8'he0, 16'h0, rd);
			`CHK("mode", d & 16'h000f, rd)
			acc(1'b1, 1'b1, 8'he2, trig, rd);
			acc(1'b0, 1'b0, 8'h4a, 16'h0, rd);
			`CHK("trigger", trig, rd)
			acc(1'b0, 1'b1, 8'h4c, 16'hffff, rd);
			req_p = rq;
			wait_frame();
			`CHK("start width", exp_len(w[1:0]), start_len)
			`CHK("recovery drive", !d[0], rec_oe)
			wait_frame();
			req_p = '0;
			wait_frame();
			repeat (60) @(negedge sys_clk);
			acc(1'b1, 1'b0, 8'he4, 16'h0, rd);
			`CHK("level status", rq & trig, rd)
			d = $random(seed);
			// odd passes clear through the config space alias
			acc(w[0], 1'b1, w[0] ? 8'he4 : 8'h4c, d, rd);
			acc(1'b0, 1'b0, 8'h4c, 16'h0, rd);
			`CHK("status clear", rq & trig & ~d, rd)
		end
		// quiet mode: no frame until the peripheral asks for one
		acc(1'b0, 1'b1, 8'h48, 16'h0002, rd);
		repeat (80) @(negedge sys_clk);
		f = frames;
		repeat (200) @(negedge sys_clk);
		`CHK("quiet idle", f, frames)
		start_req = 1'b1;
		@(negedge sys_clk) start_req = 1'b0;
		for (i = 0; i < 100 && frames == f; i++) @(negedge sys_clk);
		`CHK("quiet start", f + 1, frames)
		// partial byte enables: a mode write without the low byte is ignored
		be_sel = 2'h2;
		acc(1'b1, 1'b1, 8'he0, 16'h000d, rd);
		be_sel = 2'h3;
		acc(1'b0, 1'b0, 8'h48, 16'h0, rd);
		`CHK("mode byte enable", 16'h0002, rd)
		// a low-byte trigger write leaves the high byte alone
		acc(1'b0, 1'b1, 8'h4a, 16'hffff, rd);
		be_sel = 2'h1;
		acc(1'b1, 1'b1, 8'he2, 16'h0000, rd);
		be_sel = 2'h3;
		acc(1'b1, 1'b0, 8'he2, 16'h0, rd);
		`CHK("trigger byte enable", 16'hff00, rd)
		// both synchronous clears empty the trigger register
		for (i = 0; i < 2; i++) begin
			acc(1'b0, 1'b1, 8'h4a, 16'hffff, rd);
			@(negedge sys_clk);
			if (i == 0) fundamental_reset_n = 1'b0;
			else global_reset_n = 1'b0;
			@(negedge sys_clk);
			fundamental_reset_n = 1'b1;
			global_reset_n = 1'b1;
			acc(1'b1, 1'b0, 8'he2, 16'h0, rd);
			`CHK("trigger after clear", 16'h0000, rd)
		end
		finish_test();
	end
endmodule : testbench
